/* rtl/sic_pkg.sv */
package sic_pkg;

  // register byte offsets on the host side
  localparam logic [7:0] SIC_OFS_SELF_ID_TRACKING      = 8'h68;
  localparam logic [7:0] SIC_OFS_UPPER_CHAN_ENABLE_SET = 8'h70;
  localparam logic [7:0] SIC_OFS_UPPER_CHAN_ENABLE_CLR = 8'h74;

  // self_id_tracking field layout
  localparam int SIC_FAULT_BIT = 31;
  localparam int SIC_ROUND_LSB = 16;
  localparam int SIC_ROUND_MSB = 23;
  localparam int SIC_TALLY_LSB = 2;
  localparam int SIC_TALLY_MSB = 10;
  localparam int SIC_ROUND_W   = SIC_ROUND_MSB - SIC_ROUND_LSB + 1;
  localparam int SIC_TALLY_W   = SIC_TALLY_MSB - SIC_TALLY_LSB + 1;

  // reset values and tally limit
  localparam logic [SIC_ROUND_W-1:0] SIC_ROUND_RESET = 8'h00;
  localparam logic [SIC_TALLY_W-1:0] SIC_TALLY_RESET = 9'h000;
  localparam logic [SIC_TALLY_W-1:0] SIC_TALLY_MAX   = 9'h1FF;
  localparam logic [31:0]            SIC_MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0]            SIC_READ_ZERO   = 32'h0000_0000;

  // isochronous channel numbering
  localparam int         SIC_CHAN_W     = 6;
  localparam int         SIC_CHAN_SEL_W = 5;
  localparam int         SIC_CHAN_UPPER = 5;

  typedef enum logic {
    SIC_RX_IDLE,
    SIC_RX_ACTIVE
  } sic_rx_state_type;

endpackage

/* rtl/sic_upper_chan_mask.sv */
`timescale 1ns/1ps
`default_nettype none
module sic_upper_chan_mask
  import sic_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // register writes
  input  wire logic                  set_we_i,
  input  wire logic                  clr_we_i,
  input  wire logic [31:0]           wdata_i,
  // packet filter
  input  wire logic                  iso_valid_i,
  input  wire logic [SIC_CHAN_W-1:0] iso_chan_i,
  output logic [31:0]                mask_o,
  output logic                       iso_accept_o,
  output logic                       iso_discard_o
);

  logic upper_hit;
  logic mask_bit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_o <= SIC_MASK_RESET;
    end else if (set_we_i) begin
      mask_o <= mask_o | wdata_i;
    end else if (clr_we_i) begin
      mask_o <= mask_o & ~wdata_i;
    end
  end

  // channels 0..31 belong to the lower mask, which lives elsewhere; pass them
  assign upper_hit = iso_chan_i[SIC_CHAN_UPPER];
  // bit n enables channel n + 32, so bit 0 is channel 32 and bit 31 is 63
  assign mask_bit = mask_o[iso_chan_i[SIC_CHAN_SEL_W-1:0]];
  assign iso_accept_o  = iso_valid_i && (!upper_hit || mask_bit);
  assign iso_discard_o = iso_valid_i && upper_hit && !mask_bit;

  AST_SET_ONES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    set_we_i |=> ((mask_o & $past(wdata_i)) == $past(wdata_i))
                 && ((mask_o & ~$past(wdata_i)) == ($past(mask_o) & ~$past(wdata_i))))
    else $error("set write did not set exactly the written bits");

  AST_CLR_ONES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    clr_we_i && !set_we_i |=> ((mask_o & $past(wdata_i)) == SIC_MASK_RESET)
                 && ((mask_o & ~$past(wdata_i)) == ($past(mask_o) & ~$past(wdata_i))))
    else $error("clear write did not clear exactly the written bits");

  AST_DISCARD_MASKED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    iso_valid_i && iso_chan_i[SIC_CHAN_UPPER]
      |-> (iso_discard_o == !mask_o[iso_chan_i[SIC_CHAN_SEL_W-1:0]])
          && (iso_accept_o != iso_discard_o))
    else $error("upper channel filter decision wrong");

  AST_CHAN_TOP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    iso_valid_i && (iso_chan_i == 6'h3F) |-> iso_accept_o == mask_o[31])
    else $error("channel 63 not governed by mask bit 31");

  AST_CHAN_BOTTOM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    iso_valid_i && (iso_chan_i == 6'h20) |-> iso_accept_o == mask_o[0])
    else $error("channel 32 not governed by mask bit 0");

endmodule
`default_nettype wire

/* rtl/sic_selfid_status.sv */
// Notes on behaviour
// - Fault flag in bit 31 rises when a self-ID reception error is detected.
// - While the fault flag is set, self-ID buffer contents are undefined.
// - Fault flag clears when a self-ID reception completes without any error.
// - Both reception hardware errors and host write failures raise the fault flag.
// - Bus reset round counter in bits 23..16 increments on every bus reset.
// - Round counter wraps from 255 back to zero.
// - Bits 10..2 report quadlets stored in the self-ID buffer by the latest reception; a bus reset alone keeps them.
// - Quadlet tally counts the header quadlet and every self-ID data quadlet.
// - Quadlet tally returns to zero when a new self-ID reception starts.
// - Bits 30..24, 15..11 and 1..0 of the tracking register read zero.
// - Upper channel mask holds one enable bit per channel 32..63.
// - Mask bit n enables channel n plus 32; bit 31 enables channel 63.
// - Mask bit 0 enables channel 32.
// - Reading either set or clear address returns the current mask.
`timescale 1ns/1ps
`default_nettype none
module sic_selfid_status
  import sic_pkg::*;
(
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_n_i,
  // host register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic [31:0]           reg_wdata_i,
  output logic [31:0]                reg_rdata_o,
  output logic                       reg_rvalid_o,
  // link-side self-ID events, one-cycle pulses
  input  wire logic                  bus_reset_i,
  input  wire logic                  selfid_start_i,
  input  wire logic                  quadlet_stored_i,
  input  wire logic                  selfid_hw_err_i,
  input  wire logic                  host_wr_err_i,
  input  wire logic                  selfid_done_i,
  // isochronous receive filter
  input  wire logic                  iso_valid_i,
  input  wire logic [SIC_CHAN_W-1:0] iso_chan_i,
  output logic                       iso_accept_o,
  output logic                       iso_discard_o,
  // status
  output logic                       self_id_fault_flag_o,
  output logic                       selfid_buf_valid_o
);

  logic                   rst_meta;
  logic                   rst_n;
  sic_rx_state_type       rx_state;
  logic                   self_id_fault_flag;
  logic                   err_seen;
  logic [SIC_ROUND_W-1:0] bus_reset_round_counter;
  logic [SIC_TALLY_W-1:0] stored_quadlet_tally;
  logic [31:0]            upper_mask;
  logic [31:0]            tracking_word;
  logic [31:0]            next_rdata;
  logic                   err_now;
  logic                   set_we;
  logic                   clr_we;
  logic                   rx_quiet;
  logic                   rx_more;

  function automatic logic is_mask_addr(input logic [7:0] a);
    is_mask_addr = (a == SIC_OFS_UPPER_CHAN_ENABLE_SET) || (a == SIC_OFS_UPPER_CHAN_ENABLE_CLR);
  endfunction

  // reset released through two flops so every flop leaves reset on one edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign err_now = selfid_hw_err_i || host_wr_err_i;
  assign set_we  = reg_wr_i && (reg_addr_i == SIC_OFS_UPPER_CHAN_ENABLE_SET);
  assign clr_we  = reg_wr_i && (reg_addr_i == SIC_OFS_UPPER_CHAN_ENABLE_CLR);
  // event shapes used by the tally check below
  assign rx_quiet = !quadlet_stored_i && !selfid_start_i && !selfid_done_i;
  assign rx_more  = quadlet_stored_i && !selfid_start_i && !selfid_done_i;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= SIC_RX_IDLE;
    end else begin
      case (rx_state)
        SIC_RX_IDLE: begin
          if (selfid_start_i) begin
            rx_state <= SIC_RX_ACTIVE;
          end
        end
        SIC_RX_ACTIVE: begin
          if (selfid_done_i && !selfid_start_i) begin
            rx_state <= SIC_RX_IDLE;
          end
        end
        default: rx_state <= SIC_RX_IDLE;
      endcase
    end
  end

  // errors are remembered per reception so the completion verdict covers all of it
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      err_seen <= 1'b0;
    end else if (selfid_start_i) begin
      err_seen <= err_now;
    end else if (rx_state == SIC_RX_ACTIVE && err_now) begin
      err_seen <= 1'b1;
    end
  end

  // an error in the completing cycle wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      self_id_fault_flag <= 1'b0;
    end else if (err_now) begin
      self_id_fault_flag <= 1'b1;
    end else if (selfid_done_i && rx_state == SIC_RX_ACTIVE && !err_seen) begin
      self_id_fault_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_reset_round_counter <= SIC_ROUND_RESET;
    end else if (bus_reset_i) begin
      bus_reset_round_counter <= bus_reset_round_counter + 8'h01;
    end
  end

  // the tally saturates rather than wrapping so an overrun never looks short
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stored_quadlet_tally <= SIC_TALLY_RESET;
    end else if (selfid_start_i) begin
      stored_quadlet_tally <= SIC_TALLY_RESET;
    end else if (quadlet_stored_i && rx_state == SIC_RX_ACTIVE
                 && stored_quadlet_tally != SIC_TALLY_MAX) begin
      stored_quadlet_tally <= stored_quadlet_tally + 9'h001;
    end
  end

  sic_upper_chan_mask u_mask (
    .clk_i         (sys_clk_i),
    .rst_n_i       (rst_n),
    .set_we_i      (set_we),
    .clr_we_i      (clr_we),
    .wdata_i       (reg_wdata_i),
    .iso_valid_i   (iso_valid_i),
    .iso_chan_i    (iso_chan_i),
    .mask_o        (upper_mask),
    .iso_accept_o  (iso_accept_o),
    .iso_discard_o (iso_discard_o)
  );

  always_comb begin
    tracking_word = SIC_READ_ZERO;
    tracking_word[SIC_FAULT_BIT] = self_id_fault_flag;
    tracking_word[SIC_ROUND_MSB:SIC_ROUND_LSB] = bus_reset_round_counter;
    tracking_word[SIC_TALLY_MSB:SIC_TALLY_LSB] = stored_quadlet_tally;
  end

  always_comb begin
    if (reg_addr_i == SIC_OFS_SELF_ID_TRACKING) begin
      next_rdata = tracking_word;
    end else if (is_mask_addr(reg_addr_i)) begin
      next_rdata = upper_mask;
    end else begin
      next_rdata = SIC_READ_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o  <= SIC_READ_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  assign self_id_fault_flag_o = self_id_fault_flag;
  // buffer contents carry no guarantee while the fault flag stands
  assign selfid_buf_valid_o = !self_id_fault_flag && rx_state == SIC_RX_IDLE;

  AST_FAULT_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    selfid_hw_err_i |=> self_id_fault_flag_o && !selfid_buf_valid_o)
    else $error("hardware error did not raise the fault flag");

  AST_HOST_ERR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    host_wr_err_i |=> self_id_fault_flag && !selfid_buf_valid_o)
    else $error("host write error did not raise the fault flag");

  AST_FAULT_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    selfid_start_i && !err_now ##1 (!err_now && !selfid_start_i && !selfid_done_i) [*3]
      ##1 (selfid_done_i && !err_now) |=> !self_id_fault_flag_o)
    else $error("clean reception did not clear the fault flag");

  AST_ROUND_STEP: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    bus_reset_i |=> bus_reset_round_counter == $past(bus_reset_round_counter) + 8'h01)
    else $error("round counter did not advance on bus reset");

  AST_ROUND_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    bus_reset_i && bus_reset_round_counter == 8'hFF |=> bus_reset_round_counter == 8'h00)
    else $error("round counter did not wrap to zero");

  AST_ROUND_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    !bus_reset_i |=> $stable(bus_reset_round_counter))
    else $error("round counter moved without a bus reset");

  AST_TALLY_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    selfid_start_i |=> stored_quadlet_tally == SIC_TALLY_RESET)
    else $error("quadlet tally not cleared at reception start");

  AST_TALLY_COUNT: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    selfid_start_i ##1 rx_quiet ##1 rx_more ##1 rx_quiet ##1 rx_more ##1 rx_quiet
      ##1 (quadlet_stored_i && !selfid_start_i) |=> stored_quadlet_tally == 9'h003)
    else $error("header and data quadlets not all counted");

  AST_TALLY_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    reg_rd_i && reg_addr_i == SIC_OFS_SELF_ID_TRACKING
      |=> reg_rvalid_o && reg_rdata_o[SIC_TALLY_MSB:SIC_TALLY_LSB] == $past(stored_quadlet_tally)
          && reg_rdata_o[SIC_FAULT_BIT] == $past(self_id_fault_flag))
    else $error("tracking read does not show tally and flag");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    reg_rvalid_o && $past(reg_addr_i) == SIC_OFS_SELF_ID_TRACKING
      |-> reg_rdata_o[30:24] == 7'h00 && reg_rdata_o[15:11] == 5'h00
          && reg_rdata_o[1:0] == 2'h0)
    else $error("reserved tracking bits not zero");

  AST_MASK_READ: assert property (@(posedge sys_clk_i) disable iff (!rst_n)
    reg_rd_i && is_mask_addr(reg_addr_i) |=> reg_rdata_o == $past(upper_mask))
    else $error("mask read at set or clear address wrong");

endmodule
`default_nettype wire

/* sim/sic_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sic_phy_model (
  // clock
  input  wire logic clk_i,
  // self-ID events towards the link, one-cycle pulses
  output logic      bus_reset_o,
  output logic      selfid_start_o,
  output logic      quadlet_stored_o,
  output logic      selfid_hw_err_o,
  output logic      host_wr_err_o,
  output logic      selfid_done_o
);
  logic [5:0] ev;

  assign {selfid_done_o, host_wr_err_o, selfid_hw_err_o,
          quadlet_stored_o, selfid_start_o, bus_reset_o} = ev;

  initial ev = 6'h00;

  // gap lets the caller model a slow phy; several bits may pulse together
  task automatic pulse(input logic [5:0] which, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    ev <= which;
    @(posedge clk_i);
    ev <= 6'h00;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import sic_pkg::*;
  localparam logic [5:0] E_RST = 6'h01;
  localparam logic [5:0] E_GO  = 6'h02;
  localparam logic [5:0] E_QD  = 6'h04;
  localparam logic [5:0] E_HW  = 6'h08;
  localparam logic [5:0] E_HST = 6'h10;
  localparam logic [5:0] E_END = 6'h20;
  localparam logic [7:0] TRK   = SIC_OFS_SELF_ID_TRACKING;
  localparam logic [7:0] SET   = SIC_OFS_UPPER_CHAN_ENABLE_SET;
  localparam logic [7:0] CLR   = SIC_OFS_UPPER_CHAN_ENABLE_CLR;

  logic        sys_clk_i   = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic        bus_reset_i;
  logic        selfid_start_i;
  logic        quadlet_stored_i;
  logic        selfid_hw_err_i;
  logic        host_wr_err_i;
  logic        selfid_done_i;
  logic        iso_valid_i = 1'b0;
  logic [5:0]  iso_chan_i  = 6'h00;
  logic        iso_accept_o;
  logic        iso_discard_o;
  logic        self_id_fault_flag_o;
  logic        selfid_buf_valid_o;
  int          err_total   = 0;
  int          comparisons = 0;
  logic [7:0]  round       = 8'h00;

  always #50 sys_clk_i = ~sys_clk_i;

  sic_phy_model phy (
    .clk_i            (sys_clk_i),
    .bus_reset_o      (bus_reset_i),
    .selfid_start_o   (selfid_start_i),
    .quadlet_stored_o (quadlet_stored_i),
    .selfid_hw_err_o  (selfid_hw_err_i),
    .host_wr_err_o    (host_wr_err_i),
    .selfid_done_o    (selfid_done_i)
  );

  sic_selfid_status uut (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .bus_reset_i(bus_reset_i), .selfid_start_i(selfid_start_i),
    .quadlet_stored_i(quadlet_stored_i), .selfid_hw_err_i(selfid_hw_err_i),
    .host_wr_err_i(host_wr_err_i), .selfid_done_i(selfid_done_i),
    .iso_valid_i(iso_valid_i), .iso_chan_i(iso_chan_i),
    .iso_accept_o(iso_accept_o), .iso_discard_o(iso_discard_o),
    .self_id_fault_flag_o(self_id_fault_flag_o),
    .selfid_buf_valid_o(selfid_buf_valid_o)
  );

  task automatic finish_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    int n;
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    n = 0;
    #1;
    while (reg_rvalid_o !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (reg_rvalid_o !== 1'b1) begin
      err_total++;
      finish_test();
    end else begin
      `CHK(nm, e, reg_rdata_o)
    end
  endtask

  // valid stays up between probes: the filter has no side effect to repeat
  task automatic iso(input logic [5:0] ch, input logic acc);
    @(posedge sys_clk_i);
    iso_valid_i <= 1'b1;
    iso_chan_i  <= ch;
    #1;
    `CHK("iso_accept", acc, iso_accept_o)
    `CHK("iso_discard", ~acc, iso_discard_o)
  endtask

  function automatic logic [31:0] trk(input logic f, input logic [7:0] r,
                                      input logic [8:0] t);
    return {f, 7'h00, r, 5'h00, t, 2'h0};
  endfunction

  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rd(TRK, trk(1'b0, 8'h00, 9'h000), "track_rst");
    rd(SET, SIC_MASK_RESET, "mask_rst");
    wr(SET, 32'h8000_0001);
    wr(SET, 32'h0000_0000);
    rd(SET, 32'h8000_0001, "mask_set");
    rd(CLR, 32'h8000_0001, "mask_clr_rd");
    iso(6'h3F, 1'b1);
    iso(6'h20, 1'b1);
    iso(6'h21, 1'b0);
    iso(6'h05, 1'b1);
    wr(CLR, 32'h0000_0001);
    wr(CLR, 32'h0000_0000);
    rd(CLR, 32'h8000_0000, "mask_clr");
    iso(6'h20, 1'b0);
    wr(TRK, 32'hFFFF_FFFF);
    rd(8'h40, SIC_READ_ZERO, "unmapped");
    rd(TRK, trk(1'b0, 8'h00, 9'h000), "track_ro");
    // clean round; the last quadlet shares its cycle with done
    phy.pulse(E_RST, 0);
    phy.pulse(E_GO, 2);
    phy.pulse(E_QD, 0);
    phy.pulse(E_QD, 0);
    phy.pulse(E_QD | E_END, 0);
    rd(TRK, trk(1'b0, 8'h01, 9'h003), "clean");
    phy.pulse(E_RST, 0);
    phy.pulse(E_GO, 0);
    phy.pulse(E_QD, 0);
    phy.pulse(E_HW, 1);
    phy.pulse(E_END, 0);
    rd(TRK, trk(1'b1, 8'h02, 9'h001), "hw_err");
    `CHK("buf_valid", 1'b0, selfid_buf_valid_o)
    phy.pulse(E_GO, 0);
    rd(TRK, trk(1'b1, 8'h02, 9'h000), "restart");
    // fresh start with only one quadlet between start and done
    phy.pulse(E_GO, 0);
    phy.pulse(E_QD, 0);
    phy.pulse(E_END, 0);
    rd(TRK, trk(1'b0, 8'h02, 9'h001), "recover");
    `CHK("buf_valid", 1'b1, selfid_buf_valid_o)
    phy.pulse(E_GO, 0);
    phy.pulse(E_HST, 0);
    phy.pulse(E_QD, 0);
    phy.pulse(E_END, 0);
    rd(TRK, trk(1'b1, 8'h02, 9'h001), "host_err");
    `CHK("fault_flag", 1'b1, self_id_fault_flag_o)
    round = 8'h02;
    while (round != 8'hFF) begin
      phy.pulse(E_RST, 0);
      round++;
    end
    rd(TRK, trk(1'b1, 8'hFF, 9'h001), "round_top");
    phy.pulse(E_RST, 0);
    rd(TRK, trk(1'b1, 8'h00, 9'h001), "round_wrap");
    finish_test();
  end
endmodule
`default_nettype wire
